/* jtag_tap_consts.vh */
// constants for the jtag debug tap port
// assumes a 100 mhz system clock sampling the test clock pin
`ifndef JTAG_TAP_CONSTS_VH
`define JTAG_TAP_CONSTS_VH

// ------------------------------------------------------------
// tap states
// ------------------------------------------------------------
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'ha
`define ST_SHIFT_IR   4'hb
`define ST_EXIT1_IR   4'hc
`define ST_PAUSE_IR   4'hd
`define ST_EXIT2_IR   4'he
`define ST_UPD_IR     4'hf

// ------------------------------------------------------------
// instruction register
// ------------------------------------------------------------
`define IR_WIDTH      4
`define IR_CAPTURE    4'h1
`define IR_BYPASS     4'hf
`define IR_DEBUG      4'h8
`define DBG_WIDTH     16

`endif

/* tck_sync.v */
// two-flop synchroniser with rise and fall edge pulses
// assumes input is asynchronous to clk
`timescale 1ns/1ps
module tck_sync (
    clk,
    rst_n,
    din,
    level,
    rise,
    fall
);
    input  wire clk;
    input  wire rst_n;
    input  wire din;
    output wire level;
    output wire rise;
    output wire fall;

    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
    assign fall  = ~sync_reg & last_reg;
endmodule

/* jtag_debug_tap_port.v */
// jtag tap controller with a debug data register and event pulse
// assumes pins are asynchronous; test clock sampled at clk_sys
//
// Contract
// - test logic steps only on test clock edges
// - mode select sampled on rising test clock
// - data input captured on rising test clock
// - output driven only in shift states
// - output changes only on falling test clock
// - output high impedance during test reset
// - test reset low resets tap asynchronously
// - debug events within one test clock period share one low pulse
`timescale 1ns/1ps
`include "jtag_tap_consts.vh"
module jtag_debug_tap_port (
    clk_sys,
    rst_n,
    tck,
    tms,
    tdi,
    trst_n,
    debugEventIn,
    tdo,
    tdoOe,
    debug_event_n,
    debugData,
    debugUpdate
);
    input  wire        clk_sys;
    input  wire        rst_n;
    input  wire        tck;
    input  wire        tms;
    input  wire        tdi;
    input  wire        trst_n;
    input  wire        debugEventIn;
    output reg         tdo;
    output reg         tdoOe;
    output reg         debug_event_n;
    output reg  [15:0] debugData;
    output reg         debugUpdate;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire tckLevel;
    wire tckRise;
    wire tckFall;
    reg  tmsMeta;
    reg  tmsSync;
    reg  tdiMeta;
    reg  tdiSync;
    reg  trstMeta;
    reg  trstSync;

    tck_sync uTck (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .din   (tck),
        .level (tckLevel),
        .rise  (tckRise),
        .fall  (tckFall)
    );

    // trst is a reset pin: it clears the tap directly, the sync only
    // orders the release against clk_sys
    always @(posedge clk_sys or negedge trst_n) begin
        if (!trst_n) begin
            trstMeta <= 1'b0;
            trstSync <= 1'b0;
        end else begin
            trstMeta <= 1'b1;
            trstSync <= trstMeta;
        end
    end

    // tms/tdi take the same two flops as tck so they align with the tck edge pulse
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tmsMeta <= 1'b1;
            tmsSync <= 1'b1;
            tdiMeta <= 1'b1;
            tdiSync <= 1'b1;
        end else begin
            tmsMeta <= tms;
            tmsSync <= tmsMeta;
            tdiMeta <= tdi;
            tdiSync <= tdiMeta;
        end
    end

    // tap state is cleared only by test reset, so a system reset alone
    // leaves the debug state intact
    wire tapRst_n = trst_n & trstSync;

    // ------------------------------------------------------------
    // tap state machine
    // ------------------------------------------------------------
    reg [3:0] state_reg;
    reg [3:0] state_next;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ST_RESET:    state_next = tmsSync ? `ST_RESET : `ST_IDLE;
            `ST_IDLE:     state_next = tmsSync ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR:   state_next = tmsSync ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR:   state_next = tmsSync ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_SHIFT_DR: state_next = tmsSync ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_EXIT1_DR: state_next = tmsSync ? `ST_UPD_DR : `ST_PAUSE_DR;
            `ST_PAUSE_DR: state_next = tmsSync ? `ST_EXIT2_DR : `ST_PAUSE_DR;
            `ST_EXIT2_DR: state_next = tmsSync ? `ST_UPD_DR : `ST_SHIFT_DR;
            `ST_UPD_DR:   state_next = tmsSync ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR:   state_next = tmsSync ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR:   state_next = tmsSync ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_SHIFT_IR: state_next = tmsSync ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_EXIT1_IR: state_next = tmsSync ? `ST_UPD_IR : `ST_PAUSE_IR;
            `ST_PAUSE_IR: state_next = tmsSync ? `ST_EXIT2_IR : `ST_PAUSE_IR;
            `ST_EXIT2_IR: state_next = tmsSync ? `ST_UPD_IR : `ST_SHIFT_IR;
            `ST_UPD_IR:   state_next = tmsSync ? `ST_SEL_DR : `ST_IDLE;
            default:      state_next = `ST_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // rising test clock: state, shift registers
    // ------------------------------------------------------------
    reg [3:0]  irShift_reg;
    reg [3:0]  ir_reg;
    reg [15:0] drShift_reg;
    reg        bypass_reg;
    wire       selDebug = (ir_reg == `IR_DEBUG);
    wire       selBypass = (ir_reg == `IR_BYPASS);

    always @(posedge clk_sys or negedge tapRst_n) begin
        if (!tapRst_n) begin
            state_reg   <= `ST_RESET;
            irShift_reg <= 4'h0;
            ir_reg      <= `IR_BYPASS;
            drShift_reg <= 16'h0000;
            bypass_reg  <= 1'b0;
            debugData   <= 16'h0000;
            debugUpdate <= 1'b0;
        end else begin
            debugUpdate <= 1'b0;
            if (tckRise) begin
                state_reg <= state_next;
                case (state_reg)
                    `ST_RESET: begin
                        ir_reg <= `IR_BYPASS;
                    end
                    `ST_CAP_IR: begin
                        irShift_reg <= `IR_CAPTURE;
                    end
                    `ST_SHIFT_IR: begin
                        irShift_reg <= {tdiSync, irShift_reg[3:1]};
                    end
                    `ST_UPD_IR: begin
                        ir_reg <= irShift_reg;
                    end
                    `ST_CAP_DR: begin
                        drShift_reg <= debugData;
                        bypass_reg  <= 1'b0;
                    end
                    `ST_SHIFT_DR: begin
                        drShift_reg <= {tdiSync, drShift_reg[15:1]};
                        bypass_reg  <= tdiSync;
                    end
                    `ST_UPD_DR: begin
                        if (selDebug) begin
                            debugData   <= drShift_reg;
                            debugUpdate <= 1'b1;
                        end
                    end
                    default: begin
                        bypass_reg <= bypass_reg;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // falling test clock: data output and enable
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge tapRst_n) begin
        if (!tapRst_n) begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdoOe <= (state_reg == `ST_SHIFT_IR) ||
                     (state_reg == `ST_SHIFT_DR);
            if (state_reg == `ST_SHIFT_IR)
                tdo <= irShift_reg[0];
            else if (selDebug)
                tdo <= drShift_reg[0];
            else
                tdo <= bypass_reg;
        end
    end

    // ------------------------------------------------------------
    // debug event pulse, one test clock period wide
    // ------------------------------------------------------------
    // events are latched on clk_sys and shown from one falling tck edge
    // to the next; a stopped test clock holds them pending
    reg eventPending_reg;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            eventPending_reg <= 1'b0;
            debug_event_n    <= 1'b1;
        end else begin
            if (tckFall) begin
                debug_event_n    <= ~eventPending_reg;
                eventPending_reg <= debugEventIn;
            end else if (debugEventIn) begin
                eventPending_reg <= 1'b1;
            end
        end
    end
endmodule

/* jtag_host_model.sv */
// host model: test clock, mode select and data in
// assumes tdo is resolved here from the design's enable
`timescale 1ns/1ps
module jtag_host_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input  logic tdo,
    input  logic tdoOe
);
    logic lastTdo = 1'b0;
    // released line shows the inverse, not a stale value
    wire  tdoWire = tdoOe ? tdo : ~lastTdo;
    always @* if (tdoOe) lastTdo = tdo;
    initial begin
        tck = 1'b0; // clock stands still between frames
        tms = 1'b1;
        tdi = 1'b1;
    end
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        o = tdoWire;
        #40 tck = 1'b0;
    endtask
endmodule

/* jtag_debug_tap_port_properties.sv */
// checker on the tap port's pins
// assumes a bind onto the top module
`timescale 1ns/1ps
module jtag_debug_tap_port_properties (
    input logic        clk_sys,
    input logic        rst_n,
    input logic        tck,
    input logic        trst_n,
    input logic        debugEventIn,
    input logic        tdo,
    input logic        tdoOe,
    input logic        debug_event_n,
    input logic [15:0] debugData,
    input logic        debugUpdate
);
    default clocking @(posedge clk_sys); endclocking
    logic [5:0] evAge_reg;
    always @(posedge clk_sys or negedge rst_n)
        if (!rst_n) evAge_reg <= 6'h3f;
        else if (debugEventIn) evAge_reg <= 6'h00;
        else if (evAge_reg != 6'h3f) evAge_reg <= evAge_reg + 6'h01;
    property p_oeRel;
        disable iff (!trst_n) $rose(trst_n) |-> !tdoOe;
    endproperty
    a_oeRel: assert property (p_oeRel) else $error("tdo driven at release");
    property p_oeTrst;
        disable iff (!rst_n) !trst_n |-> !tdoOe && !tdo;
    endproperty
    a_oeTrst: assert property (p_oeTrst) else $error("tdo on in reset");
    // four high samples: the last fall has long settled
    property p_hold;
        disable iff (!trst_n) tck[*4] |-> $stable(tdo) && $stable(tdoOe);
    endproperty
    a_hold: assert property (p_hold) else $error("tdo moved, tck high");
    property p_evLow;
        disable iff (!rst_n) $fell(debug_event_n) |=> !debug_event_n[*6];
    endproperty
    a_evLow: assert property (p_evLow) else $error("event pulse short");
    property p_evEnd;
        disable iff (!rst_n) $fell(debug_event_n) |-> ##[6:10] debug_event_n;
    endproperty
    a_evEnd: assert property (p_evEnd) else $error("event pulse long");
    property p_evCause;
        disable iff (!rst_n) $fell(debug_event_n) |-> evAge_reg < 6'h1e;
    endproperty
    a_evCause: assert property (p_evCause) else $error("pulse sans event");
    property p_upd;
        disable iff (!trst_n) debugUpdate |=> !debugUpdate;
    endproperty
    a_upd: assert property (p_upd) else $error("update not a pulse");
    property p_dataCause;
        disable iff (!trst_n)
            $changed(debugData) |-> debugUpdate || $past(debugUpdate);
    endproperty
    a_dataCause: assert property (p_dataCause) else $error("data moved");
    c_upd: cover property (debugUpdate);
    c_ev: cover property ($fell(debug_event_n));
    c_oe: cover property ($rose(tdoOe));
endmodule
bind jtag_debug_tap_port jtag_debug_tap_port_properties chk_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .trst_n(trst_n),
    .debugEventIn(debugEventIn), .tdo(tdo), .tdoOe(tdoOe),
    .debug_event_n(debug_event_n), .debugData(debugData),
    .debugUpdate(debugUpdate));

/* tb_top.sv */
// self-checking bench for the jtag debug tap port
// assumes the host model and checker compile first
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys, rst_n, trst_n, debugEventIn, b;
    wire         tck, tms, tdi, tdo, tdoOe, debug_event_n, debugUpdate;
    wire  [15:0] debugData;
    logic [15:0] prevData, v, got;
    int          errors, n_compared, lowCnt, updCnt;
    jtag_debug_tap_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .debugEventIn(debugEventIn), .tdo(tdo), .tdoOe(tdoOe),
        .debug_event_n(debug_event_n), .debugData(debugData),
        .debugUpdate(debugUpdate));
    jtag_host_model host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // update strobes counted apart from the checker
    always @(posedge clk_sys)
        if (debugUpdate === 1'b1) updCnt++;
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic scan(input logic ir, input logic [15:0] d, input int n,
                        input int p, output logic [15:0] o);
        logic x;
        o = 16'h0000;
        host_u.tick(1'b1, 1'b0, x);
        if (ir) host_u.tick(1'b1, 1'b0, x);
        repeat (2) host_u.tick(1'b0, 1'b0, x);
        for (int i = 0; i < n; i++) begin
            host_u.tick(i == n - 1 || i == p, d[i], x);
            o[i] = x;
            // pause after bit p: exit1, pause, exit2, back to shift
            if (i == p && i != n - 1) begin
                host_u.tick(1'b0, 1'b0, x);
                chk("oePause", 16'h0000, tdoOe);
                host_u.tick(1'b1, 1'b0, x);
                host_u.tick(1'b0, 1'b0, x);
            end
        end
        host_u.tick(1'b1, 1'b0, x);
        host_u.tick(1'b0, 1'b0, x);
    endtask
    task end_of_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #500000 errors++;
        end_of_test;
    end
    initial begin
        rst_n = 1'b0;
        trst_n = 1'b0;
        debugEventIn = 1'b0;
        prevData = 16'h0000;
        void'($urandom(32'hfdd41155));
        repeat (4) @(posedge clk_sys);
        #1 chk("tdoOe", 16'h0000, tdoOe);
        rst_n = 1'b1;
        trst_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1 host_u.tick(1'b0, 1'b0, b);
        scan(1'b1, 16'h0008, 4, -1, got);
        chk("irCapture", 16'h0001, got);
        chk("tdoOeIdle", 16'h0000, tdoOe);
        for (int k = 0; k < 4; k++) begin
            v = 16'($urandom);
            if (k == 3) begin
                rst_n = 1'b0;
                repeat (3) @(posedge clk_sys);
                #1 rst_n = 1'b1;
                repeat (5) @(posedge clk_sys);
                #1;
            end
            // a pause after bit k must neither shift nor drive
            scan(1'b0, v, 16, k, got);
            chk("drOut", prevData, got);
            chk("debugData", v, debugData);
            prevData = v;
        end
        chk("updCnt", 16'h0004, updCnt[15:0]);
        // event raised while tck keeps running: pulse spans one period
        lowCnt = 0;
        fork
            repeat (4) host_u.tick(1'b0, 1'b0, b);
            begin
                repeat (2) @(posedge clk_sys);
                #1 debugEventIn = 1'b1;
                @(posedge clk_sys);
                #1 debugEventIn = 1'b0;
            end
            repeat (40) begin
                @(posedge clk_sys);
                #1 lowCnt += (debug_event_n === 1'b0);
            end
        join
        chk("eventWidth", 16'h0008, lowCnt[15:0]);
        host_u.tick(1'b1, 1'b0, b);
        repeat (3) host_u.tick(1'b0, 1'b1, b);
        chk("oeShift", 16'h0001, tdoOe);
        trst_n = 1'b0;
        #1 chk("oeTrst", 16'h0000, tdoOe);
        @(posedge clk_sys);
        #1 trst_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1 host_u.tick(1'b0, 1'b0, b);
        v = 16'($urandom);
        scan(1'b0, v, 16, -1, got);
        chk("bypass", {v[14:0], 1'b0}, got);
        chk("dataCleared", 16'h0000, debugData);
        // five rises with tms high must also fall back to bypass
        scan(1'b1, 16'h0008, 4, -1, got);
        chk("irCapture2", 16'h0001, got);
        repeat (5) host_u.tick(1'b1, 1'b0, b);
        host_u.tick(1'b0, 1'b0, b);
        v = 16'($urandom);
        scan(1'b0, v, 16, -1, got);
        chk("tmsReset", {v[14:0], 1'b0}, got);
        chk("updKeep", 16'h0004, updCnt[15:0]);
        end_of_test;
    end
endmodule
